// File: cmps_pkg.sv
// Shared constants and types for the current-mode PWM sequencer.
// Assumes one 125 MHz clock; all cycle counts below derive from it.
package cmps_pkg;

    // Clock
    localparam int CLK_MHZ = 125;
    localparam int CLK_HZ = CLK_MHZ * 1000000;

    // Switching oscillator
    localparam int SW_FREQ_HZ = 100000;
    localparam int PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
    localparam int CW = 11;
    localparam int DMAX_NUM = 3;
    localparam int DMAX_DEN = 4;

    // Frequency jitter: deviation either side and full modulation period
    localparam int JIT_HZ = 4000;
    localparam int JIT_PERIOD_MS = 4;
    localparam int JIT_DEV_CYC = PERIOD_CYC * JIT_HZ / SW_FREQ_HZ;
    localparam int JIT_PERIOD_CYC = JIT_PERIOD_MS * (CLK_HZ / 1000);
    localparam int JIT_TICK_CYC = JIT_PERIOD_CYC / (4 * JIT_DEV_CYC);
    localparam int JW = 7;

    // Soft start
    localparam int SS_STEPS = 32;
    localparam int SS_STEP_US = 600;
    localparam int SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
    localparam int SS_DONE_MS = 20;
    localparam int SS_DONE_CYC = SS_DONE_MS * (CLK_HZ / 1000);

    // Blanking and filters (least times, rounded up)
    localparam int LEB_NS = 220;
    localparam int LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;
    localparam int SWF_NS = 190;
    localparam int SWF_CYC = (SWF_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK_MS = 20;
    localparam int BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
    localparam int SPIKE_NS = 8000;
    localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;

    // Input bit positions inside the synchroniser vector
    localparam int IN_VON = 0;
    localparam int IN_VOFF = 1;
    localparam int IN_FB = 2;
    localparam int IN_SS = 3;
    localparam int IN_CL = 4;
    localparam int IN_BL = 5;
    localparam int IN_SW = 6;
    localparam int IN_FBLO = 7;
    localparam int IN_FBHI = 8;
    localparam int IN_OVL = 9;
    localparam int IN_EXT = 10;
    localparam int IN_CHG = 11;
    localparam int NIN = 12;

    typedef enum logic [5:0] {
        CMPS_OFF = 6'h01,
        CMPS_SOFT = 6'h02,
        CMPS_RUN = 6'h04,
        CMPS_BURST = 6'h08,
        CMPS_RESTART = 6'h10,
        CMPS_LATCHED = 6'h20
    } cmps_state_t;

endpackage

// File: cmps_persist.sv
// Persistence timer: output rises once the input has been high for CYC
// consecutive enabled cycles, and falls the cycle after the input drops.
// Assumes the input is already synchronous to clk.
module cmps_persist #(
    parameter int CYC = 24
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic level,
    output logic held
);
    localparam int W = $clog2(CYC + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic held;
    } cmps_persist_t;

    cmps_persist_t s_q;
    cmps_persist_t s_d;

    always_comb begin
        s_d = s_q;
        if (!level) begin
            s_d.cnt = '0;
        end else if (s_q.cnt != W'(CYC)) begin
            s_d.cnt = s_q.cnt + W'(1);
        end
        s_d.held = (s_d.cnt == W'(CYC));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign held = s_q.held;

    drop_clears_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !level) |=> !held)
        else $error("persist output stayed high after input dropped");

endmodule // cmps_persist

// File: cmps_sequencer.sv
// Timing and sequencing core of a current-mode switching controller.
// Assumes comparator and supply levels arrive asynchronously from the
// analog front end; gate_drive feeds the power switch driver.
module cmps_sequencer #(
    parameter int SS_STEP_CYC = cmps_pkg::SS_STEP_CYC,
    parameter int SS_DONE_CYC = cmps_pkg::SS_DONE_CYC,
    parameter int BLANK_CYC = cmps_pkg::BLANK_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic supply_above_on,
    input wire logic supply_above_off,
    input wire logic feedback_compare,
    input wire logic softstart_compare,
    input wire logic current_limit_compare,
    input wire logic burst_current_limit_compare,
    input wire logic short_winding_compare,
    input wire logic feedback_low,
    input wire logic feedback_high,
    input wire logic overload_detect,
    input wire logic blanking_extend_pin,
    input wire logic blanking_charged,
    output logic gate_drive,
    output logic [4:0] softstart_level,
    output logic softstart_sink_on,
    output logic burst_limit_gate,
    output logic auto_restart,
    output logic latched_off,
    output logic blank_charge_enable
);
    localparam int NIN = cmps_pkg::NIN;
    localparam int CW = cmps_pkg::CW;
    localparam int JW = cmps_pkg::JW;
    localparam int SDW = $clog2(SS_STEP_CYC);
    localparam int STW = $clog2(SS_DONE_CYC);
    localparam int TKW = $clog2(cmps_pkg::JIT_TICK_CYC);
    localparam logic [CW-1:0] PER_BASE =
        CW'(cmps_pkg::PERIOD_CYC - cmps_pkg::JIT_DEV_CYC);
    localparam logic [JW-1:0] JIT_MID = JW'(cmps_pkg::JIT_DEV_CYC);
    localparam logic [JW-1:0] JIT_TOP = JW'(2 * cmps_pkg::JIT_DEV_CYC);
    localparam logic [5:0] LEB_LOAD = 6'(cmps_pkg::LEB_CYC);
    localparam logic [4:0] SS_LAST = 5'(cmps_pkg::SS_STEPS - 1);

    typedef struct packed {
        logic [NIN-1:0] sync1;
        logic [NIN-1:0] sync2;
        cmps_pkg::cmps_state_t st;
        logic [CW-1:0] cyc;
        logic [CW-1:0] period;
        logic [CW-1:0] on_max;
        logic [JW-1:0] jit;
        logic jit_up;
        logic [TKW-1:0] jit_div;
        logic [SDW-1:0] ss_div;
        logic [STW-1:0] ss_time;
        logic [4:0] ss_level;
        logic ss_sink;
        logic [5:0] leb;
        logic gate;
        logic bk_en;
    } cmps_seq_t;

    cmps_seq_t s_q;
    cmps_seq_t s_d;

    // Switching states in which the gate may be driven
    function automatic logic is_on(input cmps_pkg::cmps_state_t st);
        return (st == cmps_pkg::CMPS_SOFT) || (st == cmps_pkg::CMPS_RUN) ||
            (st == cmps_pkg::CMPS_BURST);
    endfunction

    logic von;
    logic voff;
    logic fb_s;
    logic ss_s;
    logic cl_s;
    logic bl_s;
    logic fb_lo;
    logic fb_hi;
    logic ext_cap;
    logic in_run;
    logic in_soft;
    logic in_burst;
    logic burst_held;
    logic ovl_held;
    logic spike_held;
    logic sw_held;
    logic run_ok;
    logic cyc_end;
    logic duty_end;
    logic set_ev;
    logic blank;
    logic cmp_rst;
    logic restart_go;
    logic hard_off;
    logic rst_ev;
    logic ss_tick;
    logic ss_done;
    logic [CW-1:0] per_next;
    logic [CW+1:0] on_calc;

    assign von = s_q.sync2[cmps_pkg::IN_VON];
    assign voff = s_q.sync2[cmps_pkg::IN_VOFF];
    assign fb_s = s_q.sync2[cmps_pkg::IN_FB];
    assign ss_s = s_q.sync2[cmps_pkg::IN_SS];
    assign cl_s = s_q.sync2[cmps_pkg::IN_CL];
    assign bl_s = s_q.sync2[cmps_pkg::IN_BL];
    assign fb_lo = s_q.sync2[cmps_pkg::IN_FBLO];
    assign fb_hi = s_q.sync2[cmps_pkg::IN_FBHI];
    assign ext_cap = s_q.sync2[cmps_pkg::IN_EXT];
    assign in_run = (s_q.st == cmps_pkg::CMPS_RUN);
    assign in_soft = (s_q.st == cmps_pkg::CMPS_SOFT);
    assign in_burst = (s_q.st == cmps_pkg::CMPS_BURST);

    // Burst entry: feedback low for the whole interval, never in soft start
    cmps_persist #(.CYC(BLANK_CYC)) u_burst_blank (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .level(fb_lo && in_run),
        .held(burst_held)
    );

    // Overload must persist through the internal blanking time
    cmps_persist #(.CYC(BLANK_CYC)) u_ovl_blank (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .level(s_q.sync2[cmps_pkg::IN_OVL] && in_run),
        .held(ovl_held)
    );

    // Spike blanking after the external capacitor reaches its threshold
    cmps_persist #(.CYC(cmps_pkg::SPIKE_CYC)) u_ext_spike (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .level(s_q.sync2[cmps_pkg::IN_CHG] && ovl_held && ext_cap),
        .held(spike_held)
    );

    // Short-winding detect filter
    cmps_persist #(.CYC(cmps_pkg::SWF_CYC)) u_sw_filter (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .level(s_q.sync2[cmps_pkg::IN_SW] && is_on(s_q.st)),
        .held(sw_held)
    );

    always_comb begin
        s_d = s_q;
        s_d.sync1 = {blanking_charged, blanking_extend_pin, overload_detect,
            feedback_high, feedback_low, short_winding_compare,
            burst_current_limit_compare, current_limit_compare,
            softstart_compare, feedback_compare, supply_above_off,
            supply_above_on};
        s_d.sync2 = s_q.sync1;

        run_ok = is_on(s_q.st) && voff;
        // Extended blanking only on the restart path
        restart_go = in_run && ovl_held && (ext_cap ? spike_held : 1'b1);
        hard_off = !run_ok || sw_held || restart_go;

        // Oscillator: free running, next period picked at each cycle start
        cyc_end = (s_q.cyc == s_q.period - CW'(1));
        duty_end = (s_q.cyc == s_q.on_max - CW'(1));
        set_ev = cyc_end && run_ok;
        blank = (s_q.leb != 6'h00) || set_ev;
        cmp_rst = !blank && (fb_s || cl_s || (in_soft && ss_s) ||
            (in_burst && bl_s));
        rst_ev = hard_off || duty_end || cmp_rst;
        // Reset dominates set
        s_d.gate = (s_q.gate || set_ev) && !rst_ev;
        if (set_ev) begin
            s_d.leb = LEB_LOAD;
        end else if (s_q.leb != 6'h00) begin
            s_d.leb = s_q.leb - 6'h01;
        end

        per_next = PER_BASE + CW'(s_q.jit);
        on_calc = ((CW + 2)'(per_next) * (CW + 2)'(cmps_pkg::DMAX_NUM)) /
            (CW + 2)'(cmps_pkg::DMAX_DEN);
        if (cyc_end) begin
            s_d.cyc = '0;
            s_d.period = per_next;
            s_d.on_max = on_calc[CW-1:0];
        end else begin
            s_d.cyc = s_q.cyc + CW'(1);
        end

        // Triangle jitter only once normal operation is reached
        if (!(in_run || in_burst)) begin
            s_d.jit = JIT_MID;
            s_d.jit_up = 1'b1;
            s_d.jit_div = '0;
        end else if (s_q.jit_div == TKW'(cmps_pkg::JIT_TICK_CYC - 1)) begin
            s_d.jit_div = '0;
            if (s_q.jit_up) begin
                if (s_q.jit == JIT_TOP) begin
                    s_d.jit_up = 1'b0;
                    s_d.jit = s_q.jit - JW'(1);
                end else begin
                    s_d.jit = s_q.jit + JW'(1);
                end
            end else begin
                if (s_q.jit == '0) begin
                    s_d.jit_up = 1'b1;
                    s_d.jit = s_q.jit + JW'(1);
                end else begin
                    s_d.jit = s_q.jit - JW'(1);
                end
            end
        end else begin
            s_d.jit_div = s_q.jit_div + TKW'(1);
        end

        // Soft-start timebase
        ss_tick = (s_q.ss_div == SDW'(SS_STEP_CYC - 1));
        ss_done = (s_q.ss_time == STW'(SS_DONE_CYC - 1));
        if (in_soft) begin
            s_d.ss_time = s_q.ss_time + STW'(1);
            s_d.ss_div = ss_tick ? '0 : s_q.ss_div + SDW'(1);
            if (ss_tick && (s_q.ss_level != SS_LAST)) begin
                s_d.ss_level = s_q.ss_level + 5'h01;
            end
        end

        s_d.bk_en = in_run && ovl_held && ext_cap;

        case (s_q.st)
            cmps_pkg::CMPS_OFF: begin
                s_d.ss_div = '0;
                s_d.ss_time = '0;
                s_d.ss_level = 5'h00;
                s_d.ss_sink = 1'b0;
                if (von) begin
                    s_d.st = cmps_pkg::CMPS_SOFT;
                    s_d.ss_sink = 1'b1;
                end
            end
            cmps_pkg::CMPS_SOFT: begin
                if (ss_done) begin
                    s_d.st = cmps_pkg::CMPS_RUN;
                    s_d.ss_sink = 1'b0;
                end
            end
            cmps_pkg::CMPS_RUN: begin
                if (restart_go) begin
                    s_d.st = cmps_pkg::CMPS_RESTART;
                end else if (burst_held) begin
                    s_d.st = cmps_pkg::CMPS_BURST;
                end
            end
            cmps_pkg::CMPS_BURST: begin
                if (fb_hi) begin
                    s_d.st = cmps_pkg::CMPS_RUN;
                end
            end
            cmps_pkg::CMPS_RESTART: begin
                s_d.st = cmps_pkg::CMPS_RESTART;
            end
            cmps_pkg::CMPS_LATCHED: begin
                s_d.st = cmps_pkg::CMPS_LATCHED;
            end
            default: begin
                s_d.st = cmps_pkg::CMPS_OFF;
            end
        endcase
        // Supply collapse ends restart too, so the next start is soft
        if (s_q.st != cmps_pkg::CMPS_LATCHED && s_q.st != cmps_pkg::CMPS_OFF &&
            !voff) begin
            s_d.st = cmps_pkg::CMPS_OFF;
            s_d.ss_sink = 1'b0;
        end
        if (is_on(s_q.st) && sw_held) begin
            s_d.st = cmps_pkg::CMPS_LATCHED;
            s_d.ss_sink = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.st <= cmps_pkg::CMPS_OFF;
            s_q.period <= CW'(cmps_pkg::PERIOD_CYC);
            s_q.on_max <= CW'(cmps_pkg::PERIOD_CYC * cmps_pkg::DMAX_NUM /
                cmps_pkg::DMAX_DEN);
            s_q.jit <= JIT_MID;
            s_q.jit_up <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign gate_drive = s_q.gate;
    assign softstart_level = s_q.ss_level;
    assign softstart_sink_on = s_q.ss_sink;
    assign burst_limit_gate = s_q.st[3];
    assign auto_restart = s_q.st[4];
    assign latched_off = s_q.st[5];
    assign blank_charge_enable = s_q.bk_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !clk_en);

    sequence s_cycle_start;
        cyc_end && run_ok && !hard_off && !duty_end;
    endsequence

    sequence s_start_up;
        (s_q.st == cmps_pkg::CMPS_OFF) && von;
    endsequence

    cycle_set_a: assert property (s_cycle_start |=>
        gate_drive && s_q.cyc == '0 && s_q.leb == LEB_LOAD)
        else $error("oscillator did not set the gate at cycle start");

    reset_wins_a: assert property (rst_ev |=> !gate_drive)
        else $error("gate on after a latch reset");

    duty_max_a: assert property (gate_drive |-> s_q.cyc < s_q.on_max)
        else $error("on-time passed the duty limit");

    blank_hold_a: assert property ((gate_drive && s_q.leb > 6'h01 &&
        !hard_off && !duty_end) |=> gate_drive)
        else $error("gate cut during edge blanking");

    softstart_begin_a: assert property (s_start_up |=>
        in_soft && s_q.ss_level == 5'h00 && s_q.ss_time == '0 &&
        softstart_sink_on)
        else $error("soft start did not begin from zero");

    ss_step_a: assert property ((in_soft && ss_tick &&
        s_q.ss_level != SS_LAST && voff && !sw_held) |=>
        s_q.ss_level == $past(s_q.ss_level) + 5'h01)
        else $error("soft-start level failed to step");

    ss_end_a: assert property ((in_soft && ss_done && voff && !sw_held) |=>
        in_run && !softstart_sink_on)
        else $error("soft start did not finish on time");

    jitter_hold_a: assert property (!(in_run || in_burst) |=>
        ($past(in_run || in_burst) || s_q.jit == JIT_MID))
        else $error("frequency jitter active outside normal run");

    uvlo_gate_a: assert property (!voff |=> !gate_drive)
        else $error("gate driven below the supply off level");

    burst_entry_a: assert property ($rose(burst_limit_gate) |->
        $past(burst_held))
        else $error("burst entered without full blanking");

    sw_latch_a: assert property ((sw_held && is_on(s_q.st)) |=>
        latched_off && !gate_drive)
        else $error("short-winding fault did not latch off");

    restart_rerun_a: assert property ((auto_restart && !voff) |=>
        s_q.st == cmps_pkg::CMPS_OFF ##1 (!$past(von) || in_soft))
        else $error("restart attempt skipped soft start");

endmodule // cmps_sequencer

// File: cmps_front.sv
// Behavioural model of the analog front end facing the sequencer.
// Assumes the bench sets the trip points; gate_drive comes from the design.
module cmps_front (
    input wire logic clk,
    input wire logic gate_drive,
    input wire logic [10:0] fb_thr,
    input wire logic [10:0] ss_thr,
    input wire logic [10:0] cl_thr,
    input wire logic [10:0] bcl_thr,
    input wire logic [10:0] sw_thr,
    output logic feedback_compare,
    output logic softstart_compare,
    output logic current_limit_compare,
    output logic burst_current_limit_compare,
    output logic short_winding_compare
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] ramp_q = 11'h000;
    // Switch current ramps while on and collapses at once when off
    always_ff @(posedge clk) begin
        ramp_q <= gate_drive ? ramp_q + 11'h001 : 11'h000;
    end
    assign feedback_compare = gate_drive && ramp_q >= fb_thr;
    assign softstart_compare = gate_drive && ramp_q >= ss_thr;
    assign current_limit_compare = gate_drive && ramp_q >= cl_thr;
    assign burst_current_limit_compare = gate_drive && ramp_q >= bcl_thr;
    assign short_winding_compare = gate_drive && ramp_q >= sw_thr;
endmodule // cmps_front

// File: cmps_sequencer_bench.sv
// Self-checking bench for the PWM sequencer with an analog front model.
// Assumes cmps_pkg, cmps_persist, cmps_sequencer, cmps_front compiled.
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %0t %s", $time, m); end end
`define WAITC(c, l) begin int wn; wn = 0; \
    while (!(c) && wn < (l)) begin @(negedge clk); wn++; end \
    wait_n = wn; `CHK(wn < (l), 1'b1, "wait limit") end
module cmps_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SSTEP = 100;
    localparam int SDONE = 4000;
    localparam int BLNK = 50;
    typedef struct {
        int fb, cl, bcl, sw;
        logic low, hi;
        int on;
    } cmps_row_t;
    logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic supply_above_on = 1'b0, supply_above_off = 1'b0;
    logic feedback_low = 1'b0, feedback_high = 1'b0, overload_detect = 1'b0;
    logic blanking_extend_pin = 1'b0, blanking_charged = 1'b0;
    logic [10:0] fb_thr = 11'h7FF, ss_thr = 11'h096, cl_thr = 11'h7FF;
    logic [10:0] bcl_thr = 11'h7FF, sw_thr = 11'h7FF;
    logic feedback_compare, softstart_compare, current_limit_compare;
    logic burst_current_limit_compare, short_winding_compare, gate_drive;
    logic softstart_sink_on, burst_limit_gate, auto_restart, latched_off;
    logic blank_charge_enable;
    logic [4:0] softstart_level;
    int fail_count = 0, checked = 0, cyc = 0, wait_n, on_t, per, d;
    int last_rise = 0, pmin = 9999, pmax = 0;
    cmps_row_t rows [8] = '{
        '{200, 2047, 100, 2047, 1'b0, 1'b0, 203},
        '{2047, 400, 2047, 2047, 1'b0, 1'b0, 403},
        '{2047, 2047, 2047, 2047, 1'b0, 1'b0, 937},
        '{5, 2047, 2047, 2047, 1'b0, 1'b0, 28},
        '{2047, 20, 2047, 2047, 1'b0, 1'b0, 28},
        '{2047, 2047, 100, 2047, 1'b1, 1'b0, 103},
        '{60, 2047, 2047, 2047, 1'b1, 1'b0, 63},
        '{300, 2047, 2047, 300, 1'b0, 1'b1, 303}
    };

    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    cmps_sequencer #(
        .SS_STEP_CYC(SSTEP),
        .SS_DONE_CYC(SDONE),
        .BLANK_CYC(BLNK)
    ) i_cmps_sequencer (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .supply_above_on(supply_above_on),
        .supply_above_off(supply_above_off),
        .feedback_compare(feedback_compare),
        .softstart_compare(softstart_compare),
        .current_limit_compare(current_limit_compare),
        .burst_current_limit_compare(burst_current_limit_compare),
        .short_winding_compare(short_winding_compare),
        .feedback_low(feedback_low),
        .feedback_high(feedback_high),
        .overload_detect(overload_detect),
        .blanking_extend_pin(blanking_extend_pin),
        .blanking_charged(blanking_charged),
        .gate_drive(gate_drive),
        .softstart_level(softstart_level),
        .softstart_sink_on(softstart_sink_on),
        .burst_limit_gate(burst_limit_gate),
        .auto_restart(auto_restart),
        .latched_off(latched_off),
        .blank_charge_enable(blank_charge_enable)
    );

    cmps_front i_cmps_front (
        .clk(clk),
        .gate_drive(gate_drive),
        .fb_thr(fb_thr),
        .ss_thr(ss_thr),
        .cl_thr(cl_thr),
        .bcl_thr(bcl_thr),
        .sw_thr(sw_thr),
        .feedback_compare(feedback_compare),
        .softstart_compare(softstart_compare),
        .current_limit_compare(current_limit_compare),
        .burst_current_limit_compare(burst_current_limit_compare),
        .short_winding_compare(short_winding_compare)
    );

    task automatic summarize();
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic supply(input logic v);
        @(posedge clk);
        supply_above_on <= v;
        supply_above_off <= v;
    endtask

    task automatic set_row(input cmps_row_t r);
        @(posedge clk);
        fb_thr <= 11'(r.fb);
        cl_thr <= 11'(r.cl);
        bcl_thr <= 11'(r.bcl);
        sw_thr <= 11'(r.sw);
        feedback_low <= r.low;
        feedback_high <= r.hi;
    endtask

    // Measures the next whole gate pulse and the spacing of its start
    task automatic pulse();
        `WAITC(gate_drive !== 1'b1, 3000)
        `WAITC(gate_drive === 1'b1, 3000)
        per = cyc - last_rise;
        last_rise = cyc;
        `WAITC(gate_drive !== 1'b1, 3000)
        on_t = cyc - last_rise;
        // Jitter moves the period by at most one cycle between two starts
        `CHK(on_t * 4 <= (per + 1) * 3, 1'b1, "above max duty")
    endtask

    task automatic ss_check();
        int n, steps, last;
        logic [4:0] prev;
        n = 0;
        steps = 0;
        last = 0;
        `WAITC(softstart_sink_on === 1'b1, 10)
        `CHK(softstart_level, 5'h00, "soft start not at zero")
        prev = 5'h00;
        while (softstart_sink_on === 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
            if (softstart_level !== prev) begin
                `CHK(softstart_level, prev + 5'h01, "step size")
                if (steps > 0) `CHK(n - last, SSTEP, "step spacing")
                steps++;
                last = n;
                prev = softstart_level;
            end
        end
        `CHK(steps, 31, "step count")
        `CHK(n >= SDONE - 3 && n <= SDONE + 3, 1'b1, "soft start end")
    endtask

    task automatic restart_supply();
        supply(1'b0);
        repeat (5) @(posedge clk);
        supply(1'b1);
        ss_check();
    endtask

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (100) @(negedge clk);
        `CHK(gate_drive, 1'b0, "gate on below on-level")
        `CHK(softstart_sink_on, 1'b0, "soft start early")
        supply(1'b1);
        fork
            ss_check();
            begin
                pulse();
                pulse();
                `CHK(per, 1250, "period in soft start")
                `CHK(on_t >= 151 && on_t <= 155, 1'b1, "ss cut")
            end
        join
        foreach (rows[i]) begin
            set_row(rows[i]);
            pulse();
            pulse();
            d = on_t - rows[i].on;
            `CHK(d >= -2 && d <= 2, 1'b1, "on-time")
            `CHK(burst_limit_gate, rows[i].low, "burst flag")
            `CHK(latched_off, 1'b0, "latched on spike")
            `CHK(per >= 1200 && per <= 1300, 1'b1, "jitter range")
            pmin = per < pmin ? per : pmin;
            pmax = per > pmax ? per : pmax;
        end
        `CHK(pmax != pmin, 1'b1, "no jitter")
        @(posedge clk);
        fb_thr <= 11'h7FF;
        sw_thr <= 11'h7FF;
        `WAITC(gate_drive === 1'b1, 1300)
        supply(1'b0);
        `WAITC(gate_drive === 1'b0, 10)
        `CHK(wait_n <= 5, 1'b1, "gate late on supply loss")
        restart_supply();
        @(posedge clk);
        overload_detect <= 1'b1;
        repeat (30) @(posedge clk);
        overload_detect <= 1'b0;
        repeat (40) @(negedge clk);
        `CHK(auto_restart, 1'b0, "restart on short overload")
        @(posedge clk);
        overload_detect <= 1'b1;
        `WAITC(auto_restart === 1'b1, 100)
        `CHK(wait_n >= BLNK && wait_n <= BLNK + 8, 1'b1, "blanking")
        `CHK(gate_drive, 1'b0, "gate in restart")
        @(posedge clk);
        overload_detect <= 1'b0;
        restart_supply();
        @(posedge clk);
        blanking_extend_pin <= 1'b1;
        overload_detect <= 1'b1;
        `WAITC(blank_charge_enable === 1'b1, 100)
        `CHK(wait_n >= BLNK && wait_n <= BLNK + 8, 1'b1, "charge")
        `CHK(auto_restart, 1'b0, "restart not extended")
        @(posedge clk);
        blanking_charged <= 1'b1;
        repeat (500) @(posedge clk);
        blanking_charged <= 1'b0;
        repeat (10) @(negedge clk);
        `CHK(auto_restart, 1'b0, "restart inside spike time")
        @(posedge clk);
        blanking_charged <= 1'b1;
        `WAITC(auto_restart === 1'b1, 1100)
        `CHK(wait_n >= 1000 && wait_n <= 1008, 1'b1, "spike time")
        @(posedge clk);
        overload_detect <= 1'b0;
        blanking_charged <= 1'b0;
        blanking_extend_pin <= 1'b0;
        restart_supply();
        @(posedge clk);
        sw_thr <= 11'h064;
        `WAITC(latched_off === 1'b1, 3000)
        `CHK(gate_drive, 1'b0, "gate after latch-off")
        supply(1'b0);
        repeat (5) @(posedge clk);
        supply(1'b1);
        repeat (20) @(negedge clk);
        `CHK(latched_off, 1'b1, "latch lost on supply cycle")
        @(posedge clk);
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        `CHK(latched_off, 1'b0, "latch kept past reset")
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule // cmps_sequencer_bench
